// file: rtl/pstio_pkg.sv
// Package for the programmable shifter/timer I/O engine.
// Assumes one clock domain (mclk) and a plain register port.
package pstio_pkg;
    localparam int NUM_SHIFT = 8;
    localparam int NUM_TIMER = 8;
    localparam int NUM_PIN = 32;
    localparam int SH_W = 32;
    localparam int TM_W = 16;
    localparam int ADDR_W = 8;
    localparam int SYNC_STAGES = 3;

    // Register map (byte addresses, word per register)
    localparam logic [7:0] REG_RESOURCE_COUNT_REGISTER = 8'h00;
    localparam logic [7:0] REG_PIN_IN = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PIN_POL = 8'h0C;
    localparam logic [7:0] REG_SH_CFG = 8'h40;
    localparam logic [7:0] REG_SH_BUF = 8'h60;
    localparam logic [7:0] REG_TM_CFG = 8'h80;
    localparam logic [7:0] REG_TM_CMP = 8'hA0;
    localparam logic [7:0] REG_SH_BUFO = 8'hC0;
    localparam logic [7:0] BANK_MASK = 8'hE0;
    localparam logic [7:0] IDX_SHIFT = 8'h02;

    // Shifter config fields
    localparam int SC_MODE_LO = 0;
    localparam int SC_PIN_LO = 2;
    localparam int SC_TMR_LO = 8;
    localparam int SC_WID_LO = 11;
    localparam int SC_NEG = 13;
    localparam int SC_CHAIN = 14;
    localparam int SC_PINOE = 15;

    // Timer config fields
    localparam int TC_MODE_LO = 0;
    localparam int TC_TRG_LO = 2;
    localparam int TC_TRGSRC_LO = 8;
    localparam int TC_TRGPOL = 10;
    localparam int TC_PIN_LO = 11;
    localparam int TC_DEC_LO = 16;
    localparam int TC_PINOE = 18;
    localparam int TC_DIS_LO = 19;

    typedef enum logic [1:0] {
        PSTIO_SH_OFF = 2'b00,
        PSTIO_SH_TX = 2'b01,
        PSTIO_SH_RX = 2'b10
    } pstio_shmode_t;

    typedef enum logic [1:0] {
        PSTIO_TM_OFF = 2'b00,
        PSTIO_TM_BAUD = 2'b01,
        PSTIO_TM_CNT16 = 2'b10
    } pstio_tmmode_t;

    // Width codes: 0=serial,1=4,2=8,3=16; full 32 via chain, see wid_bits
    typedef enum logic [1:0] {
        PSTIO_TRG_SHF = 2'b00,
        PSTIO_TRG_PIN = 2'b01,
        PSTIO_TRG_EXT = 2'b10,
        PSTIO_TRG_TMR = 2'b11
    } pstio_trgsrc_t;

    localparam logic [1:0] DEC_MCLK = 2'h0;
    localparam logic [1:0] DEC_PIN = 2'h1;
    localparam logic [1:0] DEC_TMR = 2'h2;
endpackage : pstio_pkg

// file: rtl/pstio_link_if.sv
// Timer to shifter links inside the engine.
// Assumes all parties clocked on mclk.
interface pstio_link_if;
    import pstio_pkg::*;
    logic [NUM_TIMER-1:0] shift_clk;
    logic [NUM_TIMER-1:0] load_evt;
    logic [NUM_TIMER-1:0] tm_out;
    logic [NUM_SHIFT-1:0] sh_flag;
    modport timers (output shift_clk, output load_evt, output tm_out,
        input sh_flag);
    modport shifters (input shift_clk, input load_evt, input tm_out,
        output sh_flag);
endinterface : pstio_link_if

// file: rtl/pstio_timer.sv
// One 16-bit timer: dual 8-bit baud/bit or single 16-bit counter.
// Assumes synchronised inputs; trigger already polarity-corrected.
module pstio_timer
    import pstio_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [1:0] mode,
    input wire logic [TM_W-1:0] cmp,
    input wire logic trig,
    input wire logic dec_tick,
    input wire logic dis_on_cmp,
    output logic shift_clk,
    output logic load_evt,
    output logic tm_out
);
    logic run_ff, nxt_run;
    logic [TM_W-1:0] cnt_ff, nxt_cnt;
    logic clk_ff, nxt_clk;
    logic ld_ff, nxt_ld;

    always_comb begin
        nxt_run = run_ff;
        nxt_cnt = cnt_ff;
        nxt_clk = clk_ff;
        nxt_ld = 1'b0;
        if (mode == PSTIO_TM_OFF) begin
            nxt_run = 1'b0;
            nxt_clk = 1'b0;
        end else if (!run_ff) begin
            if (trig) begin
                nxt_run = 1'b1;
                nxt_cnt = cmp;
                nxt_ld = 1'b1;
                nxt_clk = 1'b0;
            end
        end else if (dec_tick) begin
            if (mode == PSTIO_TM_BAUD) begin
                if (cnt_ff[7:0] == 8'h00) begin
                    nxt_clk = ~clk_ff;
                    nxt_cnt[7:0] = cmp[7:0];
                    if (cnt_ff[15:8] == 8'h00) begin
                        nxt_run = ~dis_on_cmp;
                        nxt_cnt = cmp;
                        nxt_ld = ~dis_on_cmp ? 1'b1 : 1'b0;
                    end else begin
                        nxt_cnt[15:8] = cnt_ff[15:8] - 8'h01;
                    end
                end else begin
                    nxt_cnt[7:0] = cnt_ff[7:0] - 8'h01;
                end
            end else begin
                // Counts decrement ticks (mclk, pin or neighbour timer) while the trigger holds
                nxt_clk = ~clk_ff;
                if (cnt_ff == '0) begin
                    nxt_cnt = cmp;
                    nxt_run = ~dis_on_cmp;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
        end
        if (mode == PSTIO_TM_CNT16 && !trig) begin
            nxt_run = 1'b0;
            nxt_clk = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            run_ff <= 1'b0;
            cnt_ff <= '0;
            clk_ff <= 1'b0;
            ld_ff <= 1'b0;
        end else begin
            run_ff <= nxt_run;
            cnt_ff <= nxt_cnt;
            clk_ff <= nxt_clk;
            ld_ff <= nxt_ld;
        end
    end

    assign shift_clk = clk_ff;
    assign tm_out = clk_ff & run_ff;
    assign load_evt = ld_ff;
endmodule : pstio_timer

// file: rtl/pstio_shifter.sv
// One 32-bit double-buffered shifter with chain ports.
// Assumes shift clock and load strobe from the selected timer.
module pstio_shifter
    import pstio_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [1:0] mode,
    input wire logic [5:0] nbits,
    input wire logic shift_evt,
    input wire logic load_evt,
    input wire logic buf_wr,
    input wire logic [SH_W-1:0] buf_wdata,
    input wire logic [SH_W-1:0] in_bits,
    output logic [SH_W-1:0] buf_q,
    output logic [SH_W-1:0] sh_q,
    output logic flag,
    output logic [5:0] beat_cnt
);
    logic [SH_W-1:0] buf_ff, nxt_buf, sh_ff, nxt_sh;
    logic flag_ff, nxt_flag;
    logic [5:0] bc_ff, nxt_bc;
    logic [SH_W-1:0] shifted;

    always_comb begin
        shifted = (sh_ff >> nbits) | (in_bits << (6'd32 - nbits));
        nxt_buf = buf_ff;
        nxt_sh = sh_ff;
        nxt_flag = flag_ff;
        nxt_bc = bc_ff;
        if (mode == PSTIO_SH_TX) begin
            if (load_evt) begin
                nxt_sh = buf_ff;
                nxt_flag = 1'b1;
                nxt_bc = '0;
            end else if (shift_evt) begin
                nxt_sh = shifted;
                nxt_bc = bc_ff + 6'd1;
            end
            if (buf_wr) begin
                nxt_buf = buf_wdata;
                nxt_flag = 1'b0;
            end
        end else if (mode == PSTIO_SH_RX) begin
            if (shift_evt) begin
                nxt_sh = shifted;
                nxt_bc = bc_ff + 6'd1;
            end
            if (load_evt && bc_ff != '0) begin
                nxt_buf = sh_ff;
                nxt_flag = 1'b1;
                nxt_bc = '0;
            end
        end else begin
            nxt_flag = 1'b0;
            nxt_bc = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            buf_ff <= '0;
            sh_ff <= '0;
            flag_ff <= 1'b0;
            bc_ff <= '0;
        end else begin
            buf_ff <= nxt_buf;
            sh_ff <= nxt_sh;
            flag_ff <= nxt_flag;
            bc_ff <= nxt_bc;
        end
    end

    assign buf_q = buf_ff;
    assign sh_q = sh_ff;
    assign flag = flag_ff;
    assign beat_cnt = bc_ff;
endmodule : pstio_shifter

// file: rtl/pstio_top.sv
// What this block does
// - 32-bit shifters, double buffered
// - Transmit: buffer to shifter, then out
// - Receive: pins into shifter, then buffer
// - Baud mode: low byte rate, high beats
// - Enabled timer loads compare, counts down
// - Low zero: toggle, decrement high, reload
// - Both zero: timer disables until trigger
// - Master transmit: module clock, inverted flag
// - Buffer write clears flag, starts timer
// - Slave receive: 16-bit, pin clock, pin trigger
// - Shift toward LSB; out bit0, in bit31
// - Parallel: n bits per shift clock
// - Widths 4, 8, 16, 32
// - Parallel pin outputs only shifters 0, 4; serial from any
// - Parallel pin inputs only shifters 3, 7; serial to any
// - Parallel pins consecutive from any start
// - Pins, timers, triggers freely assignable; timer-sourced trigger only from neighbour
// - Edge, pin direction, polarity configurable
// - Timer conditions from trigger, pin, neighbour
// - Read-only count register of resources
//
// Top of the shifter/timer I/O engine, register port and pin bank.
// Assumes pins arrive asynchronously; registers on a plain strobe port.
module pstio_top
    import pstio_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [NUM_PIN-1:0] pin_in,
    output logic [NUM_PIN-1:0] pin_out,
    output logic [NUM_PIN-1:0] pin_oe,
    input wire logic [NUM_TIMER-1:0] ext_trig
);
    pstio_link_if link ();

    logic [31:0] sh_cfg_ff [NUM_SHIFT];
    logic [31:0] nxt_sh_cfg [NUM_SHIFT];
    logic [31:0] tm_cfg_ff [NUM_TIMER];
    logic [31:0] nxt_tm_cfg [NUM_TIMER];
    logic [TM_W-1:0] tm_cmp_ff [NUM_TIMER];
    logic [TM_W-1:0] nxt_tm_cmp [NUM_TIMER];
    logic [NUM_PIN-1:0] pin_pol_ff, nxt_pin_pol;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [NUM_PIN-1:0] sync1_ff, sync2_ff, sync3_ff, pin_s_ff, nxt_pin_s;
    logic [NUM_PIN-1:0] pins;
    logic [NUM_PIN-1:0] nxt_pout, pout_ff, nxt_poe, poe_ff;

    logic [SH_W-1:0] buf_q [NUM_SHIFT];
    logic [SH_W-1:0] sh_q [NUM_SHIFT];
    logic [SH_W-1:0] in_bits [NUM_SHIFT];
    logic [5:0] beats [NUM_SHIFT];
    logic [5:0] nbits [NUM_SHIFT];
    logic [NUM_SHIFT-1:0] sh_evt, ld_sel, buf_wr;
    logic [NUM_TIMER-1:0] shclk_d_ff, trig, dec_tick;
    logic [NUM_TIMER-1:0] pinclk_d_ff;

    localparam logic [31:0] RESOURCE_COUNT_REGISTER_VAL = {8'(NUM_PIN), 8'(NUM_TIMER),
        8'h00, 8'(NUM_SHIFT)};

    // Tests whether an address falls in the bank at base; idx gives its index
    function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
        return (a & BANK_MASK) == base;
    endfunction : hit

    function automatic logic [2:0] idx(input logic [7:0] a);
        return 3'(a >> IDX_SHIFT);
    endfunction : idx

    function automatic logic [5:0] wid_bits(input logic [1:0] code,
        input logic chain_full);
        logic [5:0] r;
        r = 6'd1;
        case (code)
            2'h1: r = 6'd4;
            2'h2: r = 6'd8;
            2'h3: r = chain_full ? 6'd32 : 6'd16;
            default: r = 6'd1;
        endcase
        return r;
    endfunction : wid_bits

    // Pin synchroniser: counted once stages two and three agree
    always_comb begin
        nxt_pin_s = pin_s_ff;
        for (int p = 0; p < NUM_PIN; p++) begin
            if (sync2_ff[p] == sync3_ff[p]) begin
                nxt_pin_s[p] = sync3_ff[p];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            pin_s_ff <= '0;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            pin_s_ff <= nxt_pin_s;
        end
    end

    assign pins = pin_s_ff ^ pin_pol_ff;

    // Register file
    always_comb begin
        nxt_pin_pol = pin_pol_ff;
        nxt_rdata = '0;
        buf_wr = '0;
        for (int i = 0; i < NUM_SHIFT; i++) begin
            nxt_sh_cfg[i] = sh_cfg_ff[i];
        end
        for (int i = 0; i < NUM_TIMER; i++) begin
            nxt_tm_cfg[i] = tm_cfg_ff[i];
            nxt_tm_cmp[i] = tm_cmp_ff[i];
        end
        if (reg_wr) begin
            if (reg_addr == REG_PIN_POL) begin
                nxt_pin_pol = reg_wdata;
            end else if (hit(reg_addr, REG_SH_CFG)) begin
                nxt_sh_cfg[idx(reg_addr)] = reg_wdata;
            end else if (hit(reg_addr, REG_SH_BUF)) begin
                buf_wr[idx(reg_addr)] = 1'b1;
            end else if (hit(reg_addr, REG_TM_CFG)) begin
                nxt_tm_cfg[idx(reg_addr)] = reg_wdata;
            end else if (hit(reg_addr, REG_TM_CMP)) begin
                nxt_tm_cmp[idx(reg_addr)] = reg_wdata[TM_W-1:0];
            end
        end
        if (reg_rd) begin
            if (reg_addr == REG_RESOURCE_COUNT_REGISTER) begin
                nxt_rdata = RESOURCE_COUNT_REGISTER_VAL;
            end else if (reg_addr == REG_PIN_IN) begin
                nxt_rdata = pins;
            end else if (reg_addr == REG_STATUS) begin
                nxt_rdata = {24'h000000, link.sh_flag};
            end else if (reg_addr == REG_PIN_POL) begin
                nxt_rdata = pin_pol_ff;
            end else if (hit(reg_addr, REG_SH_CFG)) begin
                nxt_rdata = sh_cfg_ff[idx(reg_addr)];
            end else if (hit(reg_addr, REG_SH_BUF)) begin
                nxt_rdata = buf_q[idx(reg_addr)];
            end else if (hit(reg_addr, REG_TM_CFG)) begin
                nxt_rdata = tm_cfg_ff[idx(reg_addr)];
            end else if (hit(reg_addr, REG_TM_CMP)) begin
                nxt_rdata = {16'h0000, tm_cmp_ff[idx(reg_addr)]};
            end else if (hit(reg_addr, REG_SH_BUFO)) begin
                nxt_rdata = sh_q[idx(reg_addr)];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_pol_ff <= '0;
            rdata_ff <= '0;
            for (int i = 0; i < NUM_SHIFT; i++) begin
                sh_cfg_ff[i] <= '0;
            end
            for (int i = 0; i < NUM_TIMER; i++) begin
                tm_cfg_ff[i] <= '0;
                tm_cmp_ff[i] <= '0;
            end
        end else begin
            pin_pol_ff <= nxt_pin_pol;
            rdata_ff <= nxt_rdata;
            for (int i = 0; i < NUM_SHIFT; i++) begin
                sh_cfg_ff[i] <= nxt_sh_cfg[i];
            end
            for (int i = 0; i < NUM_TIMER; i++) begin
                tm_cfg_ff[i] <= nxt_tm_cfg[i];
                tm_cmp_ff[i] <= nxt_tm_cmp[i];
            end
        end
    end

    assign reg_rdata = rdata_ff;

    // Timers with trigger and decrement selection
    always_comb begin
        for (int t = 0; t < NUM_TIMER; t++) begin
            logic [1:0] src;
            logic [4:0] tsel;
            logic raw;
            src = tm_cfg_ff[t][TC_TRGSRC_LO +: 2];
            tsel = tm_cfg_ff[t][TC_TRG_LO +: 5];
            raw = 1'b0;
            case (src)
                PSTIO_TRG_SHF: raw = link.sh_flag[tsel[2:0]];
                PSTIO_TRG_PIN: raw = pins[tsel];
                PSTIO_TRG_EXT: raw = ext_trig[tsel[2:0]];
                PSTIO_TRG_TMR: raw = link.tm_out[(t+1) % NUM_TIMER];
                default: raw = 1'b0;
            endcase
            // Inverted shifter flag gives the transmitter start
            trig[t] = raw ^ tm_cfg_ff[t][TC_TRGPOL];
            case (tm_cfg_ff[t][TC_DEC_LO +: 2])
                DEC_MCLK: dec_tick[t] = 1'b1;
                DEC_PIN: dec_tick[t] = pins[tm_cfg_ff[t][TC_PIN_LO +: 5]]
                    & ~pinclk_d_ff[t];
                DEC_TMR: dec_tick[t] = link.shift_clk[(t + 1) % NUM_TIMER]
                    & ~shclk_d_ff[(t + 1) % NUM_TIMER];
                default: dec_tick[t] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            shclk_d_ff <= '0;
            pinclk_d_ff <= '0;
        end else begin
            shclk_d_ff <= link.shift_clk;
            for (int t = 0; t < NUM_TIMER; t++) begin
                pinclk_d_ff[t] <= pins[tm_cfg_ff[t][TC_PIN_LO +: 5]];
            end
        end
    end

    for (genvar t = 0; t < NUM_TIMER; t++) begin : g_tm
        pstio_timer u_tm (
            .mclk(mclk),
            .reset(reset),
            .mode(tm_cfg_ff[t][TC_MODE_LO +: 2]),
            .cmp(tm_cmp_ff[t]),
            .trig(trig[t]),
            .dec_tick(dec_tick[t]),
            .dis_on_cmp(tm_cfg_ff[t][TC_DIS_LO]),
            .shift_clk(link.shift_clk[t]),
            .load_evt(link.load_evt[t]),
            .tm_out(link.tm_out[t])
        );
    end

    // Shifters: event edge, input source, chain
    always_comb begin
        for (int s = 0; s < NUM_SHIFT; s++) begin
            logic [2:0] tsel;
            logic [4:0] psel;
            logic [5:0] n;
            logic rise;
            logic fall;
            tsel = sh_cfg_ff[s][SC_TMR_LO +: 3];
            psel = sh_cfg_ff[s][SC_PIN_LO +: 5];
            n = wid_bits(sh_cfg_ff[s][SC_WID_LO +: 2], sh_cfg_ff[s][SC_CHAIN]);
            nbits[s] = n;
            rise = link.shift_clk[tsel] & ~shclk_d_ff[tsel];
            fall = ~link.shift_clk[tsel] & shclk_d_ff[tsel];
            sh_evt[s] = sh_cfg_ff[s][SC_NEG] ? fall : rise;
            ld_sel[s] = link.load_evt[tsel];
            in_bits[s] = '0;
            if (s != NUM_SHIFT - 1 && sh_cfg_ff[s][SC_CHAIN]) begin
                in_bits[s] = sh_q[(s + 1) % NUM_SHIFT];
            end else if (n == 6'd1) begin
                in_bits[s][0] = pins[psel];
            end else if (s == 3 || s == 7) begin
                in_bits[s] = SH_W'({pins, pins} >> psel);
            end
        end
    end

    for (genvar s = 0; s < NUM_SHIFT; s++) begin : g_sh
        pstio_shifter u_sh (
            .mclk(mclk),
            .reset(reset),
            .mode(sh_cfg_ff[s][SC_MODE_LO +: 2]),
            .nbits(nbits[s]),
            .shift_evt(sh_evt[s]),
            .load_evt(ld_sel[s]),
            .buf_wr(buf_wr[s]),
            .buf_wdata(reg_wdata),
            .in_bits(in_bits[s]),
            .buf_q(buf_q[s]),
            .sh_q(sh_q[s]),
            .flag(link.sh_flag[s]),
            .beat_cnt(beats[s])
        );
    end

    // Pin drive: timers first, then serial shifters and parallel shifters 0 and 4
    always_comb begin
        nxt_pout = '0;
        nxt_poe = '0;
        for (int t = 0; t < NUM_TIMER; t++) begin
            if (tm_cfg_ff[t][TC_PINOE]) begin
                nxt_poe[tm_cfg_ff[t][TC_PIN_LO +: 5]] = 1'b1;
                nxt_pout[tm_cfg_ff[t][TC_PIN_LO +: 5]] = link.tm_out[t];
            end
        end
        for (int s = 0; s < NUM_SHIFT; s++) begin
            logic [4:0] psel;
            psel = sh_cfg_ff[s][SC_PIN_LO +: 5];
            if (sh_cfg_ff[s][SC_PINOE]) begin
                for (int b = 0; b < SH_W; b++) begin
                    if (b < nbits[s] && (nbits[s] == 6'd1 || s == 0 || s == 4))
                    begin
                        nxt_poe[5'(psel + b)] = 1'b1;
                        nxt_pout[5'(psel + b)] = sh_q[s][b];
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pout_ff <= '0;
            poe_ff <= '0;
        end else begin
            pout_ff <= nxt_pout ^ pin_pol_ff;
            poe_ff <= nxt_poe;
        end
    end

    assign pin_out = pout_ff;
    assign pin_oe = poe_ff;
endmodule : pstio_top

// file: bench/pstio_checker.sv
// Port checker for the shifter/timer I/O engine top.
// Assumes one mclk domain; bound onto every pstio_top instance.
module pstio_checker
    import pstio_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [NUM_PIN-1:0] pin_out,
    input wire logic [NUM_PIN-1:0] pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] RESOURCE_COUNT_REGISTER_EXP = {8'(NUM_PIN), 8'(NUM_TIMER), 8'h00,
        8'(NUM_SHIFT)};
    logic cfg_seen_ff;
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (reset);
    // Pins may only be driven once software has written something
    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_seen_ff <= 1'b0;
        end else if (reg_wr) begin
            cfg_seen_ff <= 1'b1;
        end
    end
    chk_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read answer");
    chk_resource_count_register_value: assert property (
        reg_rd && reg_addr == REG_RESOURCE_COUNT_REGISTER |=> reg_rdata == RESOURCE_COUNT_REGISTER_EXP)
        else $error("resource count register wrong");
    chk_reset_quiet: assert property (
        $fell(reset) |-> pin_oe == '0 && pin_out == '0 && reg_rdata == '0)
        else $error("outputs not idle after reset");
    chk_oe_after_cfg: assert property (
        pin_oe != '0 |-> cfg_seen_ff)
        else $error("pin driven before any configuration");
    chk_oe_static: assert property (
        !reg_wr && !$past(reg_wr) && !$past(reg_wr, 2) |=> $stable(pin_oe))
        else $error("pin direction changed without a write");
    chk_pol_readback: assert property (
        reg_wr && reg_addr == REG_PIN_POL ##2
        reg_rd && reg_addr == REG_PIN_POL |=> reg_rdata == $past(reg_wdata, 3))
        else $error("pin polarity readback wrong");
    chk_cmp_readback: assert property (
        reg_wr && reg_addr == REG_TM_CMP ##2 reg_rd && reg_addr == REG_TM_CMP
        |=> reg_rdata == ($past(reg_wdata, 3) & 32'h0000_FFFF))
        else $error("timer compare readback wrong");
    chk_unmapped_zero: assert property (
        reg_rd && reg_addr[7:5] == 3'b111 |=> reg_rdata == '0)
        else $error("unmapped read not zero");
endmodule : pstio_checker

bind pstio_top pstio_checker u_chk (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_out(pin_out),
    .pin_oe(pin_oe));

// file: bench/pstio_dev_model.sv
// Serial bus device on the pins: data on pin 0, clock on pin 1.
// Assumes pin levels settle within one mclk period.
module pstio_dev_model
    import pstio_pkg::*;
#(
    parameter logic [NUM_PIN-1:0] DEV_PAT = 32'h3C5A_96E1
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [NUM_PIN-1:0] pin_out,
    input wire logic [NUM_PIN-1:0] pin_oe,
    output logic [NUM_PIN-1:0] pin_in,
    output logic [63:0] rx_sr,
    output logic [6:0] rx_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_q;
    // Wire level: the engine wins where it drives, else our pattern
    assign pin_in = (pin_out & pin_oe) | (DEV_PAT & ~pin_oe);
    always_ff @(posedge mclk) begin
        clk_q <= pin_in[1];
        if (rst) begin
            rx_sr <= '0;
            rx_cnt <= 7'h00;
        end else if (pin_oe[1] && pin_in[1] && !clk_q) begin
            rx_sr <= {pin_in[0], rx_sr[63:1]};
            rx_cnt <= rx_cnt + 7'h01;
        end
    end
endmodule : pstio_dev_model

// file: bench/testbench.sv
// Self-checking bench for the shifter/timer I/O engine.
// Assumes the device model on pins 0 and 1 and the bound checker.
module testbench
    import pstio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] DEV_PAT = 32'h3C5A_96E1;
    localparam logic [31:0] WORD_A = 32'hA5C3_0F96;
    localparam logic [31:0] WORD_B = 32'h1E2D_B487;
    localparam logic [31:0] RESOURCE_COUNT_REGISTER_EXP = {8'(NUM_PIN), 8'(NUM_TIMER), 8'h00,
        8'(NUM_SHIFT)};
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [NUM_PIN-1:0] pin_in;
    logic [NUM_PIN-1:0] pin_out;
    logic [NUM_PIN-1:0] pin_oe;
    logic [NUM_TIMER-1:0] ext_trig = '0;
    logic [63:0] rx_sr;
    logic [6:0] rx_cnt;
    int n_mismatch = 0;
    int samples_checked = 0;

    always #4 mclk = ~mclk;

    pstio_top dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .ext_trig(ext_trig));
    pstio_dev_model #(.DEV_PAT(DEV_PAT)) u_dev (.mclk(mclk), .rst(reset),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .rx_sr(rx_sr),
        .rx_cnt(rx_cnt));

    task automatic chk(input string nm, input logic [63:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic results;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    task automatic do_reset;
        @(posedge mclk);
        reset <= 1'b1;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
        chk("pin_oe", 64'h0, 64'(pin_oe));
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), 64'(e), 64'(reg_rdata));
    endtask : rd

    // Bounded wait on the device's bit count
    task automatic wait_bits(input int n);
        int i;
        for (i = 0; i < 3000; i++) begin
            if (rx_cnt >= 7'(n)) break;
            @(posedge mclk);
        end
        if (i == 3000) begin
            chk("bit count wait", 64'(n), 64'(rx_cnt));
            results();
        end
    endtask : wait_bits

    task automatic t_regs;
        rd(REG_RESOURCE_COUNT_REGISTER, RESOURCE_COUNT_REGISTER_EXP);
        wr(REG_RESOURCE_COUNT_REGISTER, 32'hFFFF_FFFF);
        rd(REG_RESOURCE_COUNT_REGISTER, RESOURCE_COUNT_REGISTER_EXP);
        rd(8'hE4, 32'h0000_0000);
        rd(REG_STATUS, 32'h0000_0000);
        rd(REG_SH_CFG, 32'h0000_0000);
    endtask : t_regs

    task automatic t_pins;
        wr(REG_PIN_POL, 32'h0000_FFFF);
        rd(REG_PIN_POL, 32'h0000_FFFF);
        repeat (5) @(posedge mclk);
        rd(REG_PIN_IN, DEV_PAT ^ 32'h0000_FFFF);
    endtask : t_pins

    // Two back-to-back serial words; second written while first shifts
    task automatic t_tx;
        wr(REG_TM_CMP, 32'h0000_3F01);
        rd(REG_TM_CMP, 32'h0000_3F01);
        // Timer last: an idle flag reads low and would start it empty
        wr(REG_SH_CFG, 32'h0000_A001);
        wr(REG_SH_BUF, WORD_A);
        wr(REG_TM_CFG, 32'h000C_0C01);
        wait_bits(1);
        wr(REG_SH_BUF, WORD_B);
        wait_bits(64);
        chk("frame bits", 64'd64, 64'(rx_cnt));
        chk("frame data", {WORD_B, WORD_A}, rx_sr);
        repeat (300) @(posedge mclk);
        chk("idle bits", 64'd64, 64'(rx_cnt));
        rd(REG_STATUS, 32'h0000_0001);
    endtask : t_tx

    initial begin
        do_reset();
        t_regs();
        t_pins();
        do_reset();
        t_tx();
        results();
    end
endmodule : testbench
